/* src/pwmtr_bank.v */
// pwmtr_bank.v: register bank and clock-supply gate of a dual-channel
// 16-bit capture/compare/pwm timer.
// assumes a processor special-register port synchronous to clk_i; the
// counting core sits outside and reads the register outputs.
//
// Behaviour
// - peripheral enable 1 takes both single-bit and whole-byte writes.
// - system reset clears peripheral enable 1 to zero.
// - with the enable bit at 0 the timer clock is stopped and the whole timer is held in reset.
// - with the enable bit at 0 timer writes are ignored and reads give defaults, port 1 registers excepted.
// - with the enable bit at 1 the timer clock runs and all timer registers read and write.
// - timer registers may be undefined with the option frequency bit set and the enable bit clear.
// - the eight general registers are 16 bits wide and reset to all ones.
// - the function control register resets to 80h.
// - the first output master enable register resets to all ones.
// - each channel's c/d io control register is 8 bits and resets to 88h.
`timescale 1ns/1ps
`default_nettype none
`include "pwmtr_regs.vh"

module pwmtr_bank #(
  parameter NB = `PWMTR_NB,
  parameter NW = `PWMTR_NW
) (
  input wire clk_i,
  input wire rstn_i,
  input wire ce_i,
  input wire [19:0] addr_i,
  input wire wr_i,
  input wire bit_wr_i,
  input wire [2:0] bit_sel_i,
  input wire wide_i,
  input wire [15:0] wdata_i,
  input wire rd_i,
  input wire option_frequency_select_bit_i,
  input wire [15:0] status_set_i,
  output reg [15:0] rdata_o,
  output reg timer_clock_supply_enable_o,
  output reg timer_rstn_o,
  output reg [7:0] peripheral_clock_enable_1_o,
  output reg [8*NB-1:0] byte_regs_o,
  output reg [16*NW-1:0] word_regs_o,
  output reg [7:0] port_output_1_o,
  output reg [7:0] port_direction_1_o
);

  // ----------------------------------------------------------------
  // address decode functions
  // ----------------------------------------------------------------

  // byte register index, none when the address is not a timer byte reg
  function [4:0] byte_idx;
    input [19:0] a;
    begin
      case (a)
        `PWMTR_A_ELC: byte_idx = 5'h00;
        `PWMTR_A_STR: byte_idx = 5'h01;
        `PWMTR_A_MR: byte_idx = 5'h02;
        `PWMTR_A_PMR: byte_idx = 5'h03;
        `PWMTR_A_FCR: byte_idx = 5'h04;
        `PWMTR_A_OER1: byte_idx = 5'h05;
        `PWMTR_A_OER2: byte_idx = 5'h06;
        `PWMTR_A_OCR: byte_idx = 5'h07;
        `PWMTR_A_DF0: byte_idx = 5'h08;
        `PWMTR_A_DF1: byte_idx = 5'h09;
        `PWMTR_A_CR0: byte_idx = 5'h0a;
        `PWMTR_A_IORA0: byte_idx = 5'h0b;
        `PWMTR_A_IORC0: byte_idx = 5'h0c;
        `PWMTR_A_SR0: byte_idx = 5'h0d;
        `PWMTR_A_IER0: byte_idx = 5'h0e;
        `PWMTR_A_POCR0: byte_idx = 5'h0f;
        `PWMTR_A_CR1: byte_idx = 5'h10;
        `PWMTR_A_IORA1: byte_idx = 5'h11;
        `PWMTR_A_IORC1: byte_idx = 5'h12;
        `PWMTR_A_SR1: byte_idx = 5'h13;
        `PWMTR_A_IER1: byte_idx = 5'h14;
        `PWMTR_A_POCR1: byte_idx = 5'h15;
        default: byte_idx = `PWMTR_I_NONE;
      endcase
    end
  endfunction

  // word register index, none when the address is not a timer word reg
  function [3:0] word_idx;
    input [19:0] a;
    begin
      case (a)
        `PWMTR_A_CNT0: word_idx = 4'h0;
        `PWMTR_A_GRA0: word_idx = 4'h1;
        `PWMTR_A_GRB0: word_idx = 4'h2;
        `PWMTR_A_GRC0: word_idx = 4'h3;
        `PWMTR_A_GRD0: word_idx = 4'h4;
        `PWMTR_A_CNT1: word_idx = 4'h5;
        `PWMTR_A_GRA1: word_idx = 4'h6;
        `PWMTR_A_GRB1: word_idx = 4'h7;
        `PWMTR_A_GRC1: word_idx = 4'h8;
        `PWMTR_A_GRD1: word_idx = 4'h9;
        default: word_idx = `PWMTR_J_NONE;
      endcase
    end
  endfunction

  // reset value of a byte register
  function [7:0] byte_rst;
    input [4:0] i;
    begin
      case (i)
        `PWMTR_I_STR: byte_rst = `PWMTR_R_STR;
        `PWMTR_I_FCR: byte_rst = `PWMTR_R_FCR;
        `PWMTR_I_OER1: byte_rst = `PWMTR_R_OER1;
        `PWMTR_I_IORC0: byte_rst = `PWMTR_R_IORC;
        `PWMTR_I_IORC1: byte_rst = `PWMTR_R_IORC;
        default: byte_rst = `PWMTR_R_ZERO8;
      endcase
    end
  endfunction

  // new byte value for a whole-byte or a single-bit write
  function [7:0] merge;
    input [7:0] old;
    input [7:0] d;
    input bw;
    input [2:0] sel;
    reg [7:0] m;
    begin
      m = old;
      m[sel] = d[0];
      merge = bw ? m : d;
    end
  endfunction

  // ----------------------------------------------------------------
  // access qualification
  // ----------------------------------------------------------------
  wire en;
  wire any_wr;
  wire [4:0] bi;
  wire [3:0] wi;
  wire [7:0] wbyte;

  assign en = peripheral_clock_enable_1_o[`PWMTR_PERIPHERAL_CLOCK_ENABLE_1_EN];
  assign any_wr = ce_i & (wr_i | bit_wr_i);
  assign bi = byte_idx(addr_i);
  assign wi = word_idx(addr_i);
  assign wbyte = wdata_i[7:0];

  // ----------------------------------------------------------------
  // peripheral enable and port registers, always accessible
  // ----------------------------------------------------------------

  // enable register: bit or byte writes, cleared by reset
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      peripheral_clock_enable_1_o <= `PWMTR_R_ZERO8;
    end else if (any_wr && addr_i == `PWMTR_A_PERIPHERAL_CLOCK_ENABLE_1) begin
      peripheral_clock_enable_1_o <= merge(peripheral_clock_enable_1_o, wbyte, bit_wr_i, bit_sel_i)
        & `PWMTR_PERIPHERAL_CLOCK_ENABLE_1_MASK;
    end
  end

  // port output and direction stay live whatever the enable bit says
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      port_output_1_o <= `PWMTR_R_ZERO8;
      port_direction_1_o <= `PWMTR_R_PM1;
    end else if (any_wr) begin
      if (addr_i == `PWMTR_A_P1) begin
        port_output_1_o <= merge(port_output_1_o, wbyte, bit_wr_i, bit_sel_i);
      end
      if (addr_i == `PWMTR_A_PM1) begin
        port_direction_1_o <= merge(port_direction_1_o, wbyte, bit_wr_i, bit_sel_i);
      end
    end
  end

  // ----------------------------------------------------------------
  // clock gate and timer reset
  // ----------------------------------------------------------------

  // clock runs and reset lifts only with the enable bit set
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      timer_clock_supply_enable_o <= 1'b0;
      timer_rstn_o <= 1'b0;
    end else if (ce_i) begin
      timer_clock_supply_enable_o <= en;
      timer_rstn_o <= en;
    end
  end

  // ----------------------------------------------------------------
  // timer byte registers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : g_byte
      // a genvar has no bits of its own, so the index is a sized constant
      localparam [4:0] IDX = g;
      wire hit;
      wire is_sr;
      wire [7:0] set_bits;
      wire [7:0] cur;
      wire [7:0] nv;
      assign hit = any_wr & en & (bi == IDX);
      assign is_sr = (IDX == `PWMTR_I_SR0) | (IDX == `PWMTR_I_SR1);
      assign set_bits = (IDX == `PWMTR_I_SR0) ? status_set_i[7:0] :
                        (IDX == `PWMTR_I_SR1) ? status_set_i[15:8] : 8'h00;
      assign cur = byte_regs_o[8*g +: 8];
      assign nv = merge(cur, wbyte, bit_wr_i, bit_sel_i);

      // held at reset value while the timer is off; status flags are
      // cleared by writing 0 and a hardware set in the same cycle wins
      always @(posedge clk_i) begin
        if (!rstn_i) begin
          byte_regs_o[8*g +: 8] <= byte_rst(IDX);
        end else if (ce_i) begin
          if (!en) begin
            byte_regs_o[8*g +: 8] <= byte_rst(IDX);
          end else if (is_sr) begin
            byte_regs_o[8*g +: 8] <= (hit ? (cur & nv) : cur) | set_bits;
          end else if (hit) begin
            byte_regs_o[8*g +: 8] <= nv;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // timer word registers
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < NW; g = g + 1) begin : g_word
      // sized copy of the loop index for the decode compare
      localparam [3:0] IDX = g;
      wire hit;
      wire [15:0] rv;
      assign hit = ce_i & wr_i & wide_i & en & (wi == IDX);
      assign rv = (IDX == `PWMTR_J_CNT0 || IDX == `PWMTR_J_CNT1) ?
                  `PWMTR_R_CNT : `PWMTR_R_GEN;

      // general registers come out of reset as all ones
      always @(posedge clk_i) begin
        if (!rstn_i) begin
          word_regs_o[16*g +: 16] <= rv;
        end else if (ce_i) begin
          if (!en) begin
            word_regs_o[16*g +: 16] <= rv;
          end else if (hit) begin
            word_regs_o[16*g +: 16] <= wdata_i;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  reg [15:0] next_rdata;

  // timer regs already sit at defaults while disabled, so reads give them
  always @* begin
    next_rdata = 16'h0000;
    if (addr_i == `PWMTR_A_PERIPHERAL_CLOCK_ENABLE_1) begin
      next_rdata = {8'h00, peripheral_clock_enable_1_o};
    end else if (addr_i == `PWMTR_A_P1) begin
      next_rdata = {8'h00, port_output_1_o};
    end else if (addr_i == `PWMTR_A_PM1) begin
      next_rdata = {8'h00, port_direction_1_o};
    end else if (bi != `PWMTR_I_NONE) begin
      next_rdata = {8'h00, byte_regs_o[8*bi +: 8]};
    end else if (wi != `PWMTR_J_NONE) begin
      next_rdata = word_regs_o[16*wi +: 16];
    end
  end

  // read data registered one cycle after the request
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_o <= 16'h0000;
    end else if (ce_i && rd_i) begin
      rdata_o <= next_rdata;
    end
  end

endmodule // pwmtr_bank
`default_nettype wire

/* src/pwmtr_regs.vh */
// pwmtr_regs.vh: addresses, reset values and field positions of the
// timer register bank. assumes a 20-bit byte address space.
`ifndef PWMTR_REGS_VH
`define PWMTR_REGS_VH

// ----------------------------------------------------------------
// byte register addresses
// ----------------------------------------------------------------
`define PWMTR_A_PERIPHERAL_CLOCK_ENABLE_1 20'hf007a
`define PWMTR_A_ELC 20'hf0260
`define PWMTR_A_STR 20'hf0263
`define PWMTR_A_MR 20'hf0264
`define PWMTR_A_PMR 20'hf0265
`define PWMTR_A_FCR 20'hf0266
`define PWMTR_A_OER1 20'hf0267
`define PWMTR_A_OER2 20'hf0268
`define PWMTR_A_OCR 20'hf0269
`define PWMTR_A_DF0 20'hf026a
`define PWMTR_A_DF1 20'hf026b
`define PWMTR_A_CR0 20'hf0270
`define PWMTR_A_IORA0 20'hf0271
`define PWMTR_A_IORC0 20'hf0272
`define PWMTR_A_SR0 20'hf0273
`define PWMTR_A_IER0 20'hf0274
`define PWMTR_A_POCR0 20'hf0275
`define PWMTR_A_CR1 20'hf0280
`define PWMTR_A_IORA1 20'hf0281
`define PWMTR_A_IORC1 20'hf0282
`define PWMTR_A_SR1 20'hf0283
`define PWMTR_A_IER1 20'hf0284
`define PWMTR_A_POCR1 20'hf0285
`define PWMTR_A_P1 20'hfff01
`define PWMTR_A_PM1 20'hfff21

// ----------------------------------------------------------------
// word register addresses
// ----------------------------------------------------------------
`define PWMTR_A_CNT0 20'hf0276
`define PWMTR_A_GRA0 20'hf0278
`define PWMTR_A_GRB0 20'hf027a
`define PWMTR_A_GRC0 20'hfff58
`define PWMTR_A_GRD0 20'hfff5a
`define PWMTR_A_CNT1 20'hf0286
`define PWMTR_A_GRA1 20'hf0288
`define PWMTR_A_GRB1 20'hf028a
`define PWMTR_A_GRC1 20'hfff5c
`define PWMTR_A_GRD1 20'hfff5e

// ----------------------------------------------------------------
// bank indices
// ----------------------------------------------------------------
`define PWMTR_NB 22
`define PWMTR_NW 10
`define PWMTR_I_STR 5'h01
`define PWMTR_I_FCR 5'h04
`define PWMTR_I_OER1 5'h05
`define PWMTR_I_IORC0 5'h0c
`define PWMTR_I_SR0 5'h0d
`define PWMTR_I_IORC1 5'h12
`define PWMTR_I_SR1 5'h13
`define PWMTR_I_NONE 5'h1f
`define PWMTR_J_CNT0 4'h0
`define PWMTR_J_CNT1 4'h5
`define PWMTR_J_NONE 4'hf

// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define PWMTR_R_ZERO8 8'h00
`define PWMTR_R_STR 8'h0c
`define PWMTR_R_FCR 8'h80
`define PWMTR_R_OER1 8'hff
`define PWMTR_R_IORC 8'h88
`define PWMTR_R_GEN 16'hffff
`define PWMTR_R_CNT 16'h0000
`define PWMTR_R_PM1 8'hff
`define PWMTR_PERIPHERAL_CLOCK_ENABLE_1_EN 4
`define PWMTR_PERIPHERAL_CLOCK_ENABLE_1_MASK 8'hf1

`endif

/* tb/pwmtr_chk_asserts.sv */
// pwmtr_chk_asserts.sv: port checks on the timer register bank.
// assumes ce_i held high and one access per bus cycle.
`timescale 1ns/1ps
`default_nettype none
module pwmtr_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [19:0] addr_i,
  input wire logic wr_i,
  input wire logic bit_wr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [15:0] wdata_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic timer_rstn_o,
  input wire logic timer_clock_supply_enable_o,
  input wire logic [7:0] peripheral_clock_enable_1_o,
  input wire logic [175:0] byte_regs_o,
  input wire logic [159:0] word_regs_o
);
  // clock-supply enable bit as the bank holds it
  wire logic en;
  assign en = peripheral_clock_enable_1_o[4];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ----
  // assertions
  // ----
  reset_clear_a: assert property ($past(!rstn_i) |-> peripheral_clock_enable_1_o == 8'h00)
    else $error("enable register not cleared by reset");
  general_reset_a: assert property ($past(!rstn_i) |-> word_regs_o[79:16] == {4{16'hffff}})
    else $error("general registers not all ones after reset");
  gate_follow_a: assert property (timer_rstn_o == $past(en))
    else $error("timer reset does not follow enable bit");
  clock_gate_a: assert property (timer_clock_supply_enable_o == $past(en))
    else $error("timer clock gate does not follow enable bit");
  fcr_default_a: assert property ($past(!en) && !en |-> byte_regs_o[39:32] == 8'h80)
    else $error("function control not at default");
  oer_default_a: assert property ($past(!en) && !en |-> byte_regs_o[47:40] == 8'hff)
    else $error("output master enable not at default");
  iorc_default_a: assert property ($past(!en) && !en |-> byte_regs_o[103:96] == 8'h88 && byte_regs_o[151:144] == 8'h88)
    else $error("c/d io control not at default");
  write_take_a: assert property (wr_i && en && addr_i == 20'hf0266 |=> byte_regs_o[39:32] == $past(wdata_i[7:0]))
    else $error("enabled write not taken");
  bit_write_a: assert property (bit_wr_i && addr_i == 20'hf007a && bit_sel_i == 3'h4 |=> en == $past(wdata_i[0]))
    else $error("bit write to enable bit lost");
  read_back_a: assert property (rd_i && addr_i == 20'hf007a |=> rdata_o == {8'h00, $past(peripheral_clock_enable_1_o)})
    else $error("enable register read wrong");
  off_read_a: assert property (rd_i && !en && $past(!en) && addr_i == 20'hf0267 |=> rdata_o == 16'h00ff)
    else $error("disabled read not default");
endmodule // pwmtr_chk
bind pwmtr_bank pwmtr_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wr_i(wr_i),
  .bit_wr_i(bit_wr_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .timer_rstn_o(timer_rstn_o), .timer_clock_supply_enable_o(timer_clock_supply_enable_o),
  .peripheral_clock_enable_1_o(peripheral_clock_enable_1_o),
  .byte_regs_o(byte_regs_o), .word_regs_o(word_regs_o));
`default_nettype wire

/* tb/pwmtr_cpu.sv */
// pwmtr_cpu.sv: processor side of the special-register port.
// assumes requests launch on rising edges; read data sampled on the falling edge a cycle and a half later.
`timescale 1ns/1ps
`default_nettype none
module pwmtr_cpu (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output var logic [19:0] addr_o,
  output var logic wr_o,
  output var logic bit_wr_o,
  output var logic [2:0] bit_sel_o,
  output var logic wide_o,
  output var logic [15:0] wdata_o,
  output var logic rd_o
);
  logic [15:0] q;
  // ----
  // bus cycle
  // ----
  // idle bus at time zero
  initial begin
    {addr_o, wr_o, bit_wr_o, bit_sel_o, wide_o, wdata_o, rd_o} = '0;
    q = 16'h0000;
  end
  // one access: bit write takes select from d[10:8], value from d[0]
  task automatic xfer(input logic w, input logic b, input logic wd, input logic [19:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wr_o <= w;
    bit_wr_o <= b;
    bit_sel_o <= d[10:8];
    wide_o <= wd;
    wdata_o <= d;
    rd_o <= !w && !b;
    @(posedge clk_i);
    wr_o <= 1'b0;
    bit_wr_o <= 1'b0;
    rd_o <= 1'b0;
    wdata_o <= ~d; // released data no longer holds its value
    @(negedge clk_i);
    q = rdata_i;
  endtask
endmodule // pwmtr_cpu
`default_nettype wire

/* tb/tb_top.sv */
// tb_top.sv: self-checking bench for the timer register bank.
// assumes pwmtr_cpu drives the port and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [19:0] a; logic [15:0] d; logic wd;} pwmtr_row_t;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic option_frequency_select_bit_i = 1'b0;
  logic [15:0] status_set_i = 16'h0000;
  wire logic [19:0] addr;
  wire logic [2:0] bit_sel;
  wire logic [15:0] wdata;
  wire logic [15:0] rdata;
  wire logic wr, bit_wr, wide, rd;
  integer bad_count = 0;
  integer num_checks = 0;
  integer cyc = 0;
  pwmtr_row_t rows [6] = '{'{20'hf0266, 16'h00a5, 1'b0}, '{20'hf0267, 16'h005a, 1'b0},
    '{20'hf0272, 16'h0011, 1'b0}, '{20'hf0278, 16'h1234, 1'b1}, '{20'hfff5e, 16'habcd, 1'b1},
    '{20'hf0282, 16'h0077, 1'b0}};
  // ----
  // design, processor model, clock
  // ----
  pwmtr_bank dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr), .wr_i(wr), .bit_wr_i(bit_wr),
    .bit_sel_i(bit_sel), .wide_i(wide), .wdata_i(wdata), .rd_i(rd),
    .option_frequency_select_bit_i(option_frequency_select_bit_i), .status_set_i(status_set_i),
    .rdata_o(rdata), .timer_clock_supply_enable_o(), .timer_rstn_o(), .peripheral_clock_enable_1_o(),
    .byte_regs_o(), .word_regs_o(), .port_output_1_o(), .port_direction_1_o());
  pwmtr_cpu cpu (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .bit_wr_o(bit_wr),
    .bit_sel_o(bit_sel), .wide_o(wide), .wdata_o(wdata), .rd_o(rd));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ----
  // tasks
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [19:0] a, input logic [15:0] exp);
    cpu.xfer(1'b0, 1'b0, 1'b0, a, 16'h0000);
    chk(cpu.q, exp);
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    rdc(20'hf007a, 16'h0000);
    rdc(20'hf0267, 16'h00ff);
    cpu.xfer(1'b1, 1'b0, 1'b0, 20'hf0266, 16'h0011);
    rdc(20'hf0266, 16'h0080);
    cpu.xfer(1'b1, 1'b0, 1'b0, 20'hfff01, 16'h0042);
    rdc(20'hfff01, 16'h0042);
    rdc(20'hfff21, 16'h00ff);
    cpu.xfer(1'b0, 1'b1, 1'b0, 20'hf007a, 16'h0401);
    rdc(20'hf007a, 16'h0010);
    rdc(20'hf0288, 16'hffff);
    rdc(20'hf0282, 16'h0088);
    rdc(20'hf0266, 16'h0080);
    rdc(20'hf0267, 16'h00ff);
    @(posedge clk_i);
    status_set_i <= 16'h0100;
    @(posedge clk_i);
    status_set_i <= 16'h0000;
    rdc(20'hf0283, 16'h0001);
    cpu.xfer(1'b1, 1'b0, 1'b0, 20'hf0283, 16'h0000);
    rdc(20'hf0283, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      cpu.xfer(1'b1, 1'b0, rows[k].wd, rows[k].a, rows[k].d);
      rdc(rows[k].a, rows[k].d);
    end
    cpu.xfer(1'b1, 1'b0, 1'b0, 20'hf007a, 16'h00ff);
    rdc(20'hf007a, 16'h00f1);
    cpu.xfer(1'b0, 1'b1, 1'b0, 20'hf007a, 16'h0400);
    rdc(20'hf0266, 16'h0080);
    rdc(20'hf0278, 16'hffff);
    rdc(20'hf0300, 16'h0000);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    rdc(20'hf007a, 16'h0000);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
